// File: logic/cfg_device.sv
/*
  Configurable device end: power-on, reconfiguration handshake, serial
  load in active (own clock, flash) or passive (host clock) mode,
  end-of-load clocking and initialization. Assumes option inputs hold
  steady while a load runs.
*/
// Register access over AXI4-Lite and the register addresses were left to the implementer.
// Contract
// R1 - Active clock in four selectable ranges
// R2 - Chained devices never use fastest range
// R3 - Quad mode: flash gives four bits per clock
// R4 - Active mode launches and captures on falling edge
// R5 - Request low in user mode restarts configuration
// R6 - Status held low through power-on delay
// R7 - Done low from power-up through load
// R8 - Done and status low within 600 ns
// R9 - Host holds request low at least 2 us
// R10 - Status low 268 us, released by 1506 us
// R11 - Host waits before first clock rise
// R12 - Passive bit taken on rising clock edge
// R13 - Done released only after all data taken
// R14 - Two falling edges after done start initialization
// R15 - Data pin becomes user input afterwards
// R16 - Init-done output driven low once enabled
// R17 - Oscillator init: user mode 175 to 437 us
// R18 - User clock enabled late, then 8576 cycles
// R19 - Init needs 8576 clocks from allowed source
// R20 - Active mode init from oscillator or user clock
// R21 - Host treats status fall as error, restarts
module cfg_device
  import cfg_pkg::*;
#(
  parameter int LOAD_BITS = 256,
  parameter int STATUS_CYC = (STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter int INIT_OSC_CYC = (CD2UM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter int INIT_CLK_COUNT = INIT_CLOCKS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration pins
  cfg_link_if.device link,
  // Options, steady during a load
  input wire logic active_serial_mode,
  input wire logic quad_mode,
  input wire logic [1:0] clock_range,
  input wire logic chain_mode,
  input wire init_src_type init_src,
  input wire logic init_done_enable,
  input wire logic data_pin_user,
  input wire logic user_init_clock,
  // Load stream and state
  output logic rx_valid,
  output logic [3:0] rx_data,
  output logic user_mode,
  output logic user_data_in
);
  if (LOAD_BITS < 4 || LOAD_BITS % 4 != 0) begin : g_chk_load
    $error("LOAD_BITS must be a positive multiple of 4");
  end
  if (STATUS_CYC < 1 || STATUS_CYC > STATUS_MAX_US * 1000 / CLK_NS) begin : g_chk_status
    $error("STATUS_CYC out of range");
  end
  if (INIT_OSC_CYC < 1 || INIT_OSC_CYC > CD2UM_MAX_US * 1000 / CLK_NS) begin : g_chk_init
    $error("INIT_OSC_CYC out of range");
  end

  typedef enum logic [3:0] {
    D_POR, D_CLEAR, D_STATUS, D_CMD, D_LOAD, D_EDGES, D_CU, D_INIT, D_USER
  } dstate_type;

  typedef struct packed {
    dstate_type st;
    logic [31:0] cnt;
    logic [31:0] bits;
    logic [3:0] div;
    logic ck;
    logic ck_oe;
    logic [31:0] sh;
    logic cmd_out;
    logic cs_n;
    logic status_oe;
    logic done_oe;
    logic init_oe;
    logic umode;
    logic rx_valid;
    logic [3:0] rx_data;
    logic udata;
    logic prev_ck;
    logic prev_uc;
    logic armed;
    logic [1:0] edges;
  } dev_type;

  dev_type q_q;
  dev_type q_d;

  logic [8:0] sy;
  logic s_req;
  logic s_ck;
  logic s_data;
  logic s_uc;
  logic s_status;
  logic [3:0] s_fl;
  logic [3:0] half;
  logic tick;
  logic my_fall;
  logic take;
  logic rise_any;
  logic fall_any;
  logic init_inc;
  logic [31:0] init_lim;
  logic [31:0] step;

  // Every pin here is asynchronous to aclk
  cfg_sync #(.W(9), .INIT(9'h1ff)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.request_n, link.config_clock, link.serial_config_data, user_init_clock,
        link.status_n, link.flash_data_lines}),
    .q(sy)
  );
  assign {s_req, s_ck, s_data, s_uc, s_status, s_fl} = sy;

  assign half = half_period(clock_range, chain_mode); // R1 R2
  assign step = (active_serial_mode && quad_mode) ? 32'h4 : 32'h1; // R3

  always_comb begin
    q_d = q_q;
    q_d.rx_valid = 1'b0;
    q_d.prev_ck = s_ck;
    q_d.prev_uc = s_uc;
    tick = 1'b0;
    if (q_q.ck_oe) begin
      if (q_q.div == half - 4'h1) begin
        q_d.div = 4'h0;
        q_d.ck = !q_q.ck;
        tick = 1'b1;
      end else begin
        q_d.div = q_q.div + 4'h1;
      end
    end
    my_fall = tick && q_q.ck;
    // Own clock in active mode, host clock otherwise
    take = active_serial_mode ? my_fall : (s_ck && !q_q.prev_ck); // R4 R12
    rise_any = active_serial_mode ? (tick && !q_q.ck) : (s_ck && !q_q.prev_ck);
    fall_any = active_serial_mode ? my_fall : (!s_ck && q_q.prev_ck);
    // Config clock serves passive loads only
    unique case (init_src) // R19 R20
      SRC_USER: begin
        init_inc = s_uc && !q_q.prev_uc;
        init_lim = 32'(INIT_CLK_COUNT);
      end
      SRC_CFGCLK: begin
        init_inc = active_serial_mode ? 1'b1 : (s_ck && !q_q.prev_ck);
        init_lim = active_serial_mode ? 32'(INIT_OSC_CYC) : 32'(INIT_CLK_COUNT);
      end
      default: begin
        init_inc = 1'b1;
        init_lim = 32'(INIT_OSC_CYC);
      end
    endcase

    unique case (q_q.st)
      D_POR: begin
        q_d.cnt = q_q.cnt + 32'h1;
        if (q_q.cnt == 32'(POR_CYC - 1)) begin // R6
          q_d.st = D_STATUS;
          q_d.cnt = 32'(STATUS_CYC);
        end
      end
      D_CLEAR: begin
        if (s_req) begin
          q_d.st = D_STATUS;
          q_d.cnt = 32'h0;
        end
      end
      D_STATUS: begin
        if (q_q.cnt < 32'(STATUS_CYC)) begin // R10
          q_d.cnt = q_q.cnt + 32'h1;
        end else begin
          q_d.status_oe = 1'b0;
          // An outside hold on the status line delays the load
          if (s_status) begin
            q_d.bits = 32'h0;
            q_d.div = 4'h0;
            q_d.ck = 1'b0;
            if (active_serial_mode) begin
              q_d.st = D_CMD;
              q_d.cs_n = 1'b0;
              q_d.ck_oe = 1'b1;
              q_d.cmd_out = FLASH_READ_CMD[7];
              q_d.sh = {FLASH_READ_CMD, 24'h0} << 1;
              q_d.bits = 32'h1;
            end else begin
              q_d.st = D_LOAD;
            end
          end
        end
      end
      D_CMD: begin
        if (my_fall) begin // R4
          if (q_q.bits == 32'(FLASH_HDR_BITS)) begin
            q_d.st = D_LOAD;
            q_d.bits = 32'h0;
          end else begin
            q_d.cmd_out = q_q.sh[31];
            q_d.sh = q_q.sh << 1;
            q_d.bits = q_q.bits + 32'h1;
          end
        end
      end
      D_LOAD: begin
        if (take) begin
          q_d.rx_valid = 1'b1;
          q_d.rx_data = !active_serial_mode ? {3'h0, s_data} :
                        (quad_mode ? s_fl : {3'h0, s_fl[0]}); // R3
          q_d.bits = q_q.bits + step;
          if (q_q.bits + step >= 32'(LOAD_BITS)) begin // R7 R13
            q_d.done_oe = 1'b0;
            q_d.st = D_EDGES;
            q_d.edges = 2'h0;
            q_d.armed = 1'b0;
          end
        end
      end
      D_EDGES: begin
        // Only falls after a rise seen past done count
        if (rise_any) begin
          q_d.armed = 1'b1;
        end
        if (fall_any && q_q.armed) begin // R14
          q_d.edges = q_q.edges + 2'h1;
          q_d.armed = 1'b0;
          if (q_q.edges == 2'(END_EDGES - 1)) begin
            q_d.init_oe = init_done_enable; // R16
            q_d.ck_oe = 1'b0;
            q_d.cs_n = 1'b1;
            q_d.cnt = 32'h0;
            q_d.st = (init_src == SRC_USER) ? D_CU : D_INIT;
          end
        end
      end
      D_CU: begin
        q_d.cnt = q_q.cnt + 32'h1;
        if (q_q.cnt == 32'(CU_CYC - 1)) begin // R18
          q_d.st = D_INIT;
          q_d.cnt = 32'h0;
        end
      end
      D_INIT: begin
        if (init_inc) begin // R17 R18 R19
          q_d.cnt = q_q.cnt + 32'h1;
          if (q_q.cnt == init_lim - 32'h1) begin
            q_d.st = D_USER;
            q_d.umode = 1'b1;
            q_d.init_oe = 1'b0;
          end
        end
      end
      D_USER: begin
        q_d.udata = data_pin_user && s_data; // R15
      end
    endcase

    // Request low aborts every state but power-on, user mode included
    if (!s_req && q_q.st != D_POR) begin // R5 R8
      q_d.st = D_CLEAR;
      q_d.status_oe = 1'b1;
      q_d.done_oe = 1'b1;
      q_d.init_oe = 1'b0;
      q_d.umode = 1'b0;
      q_d.udata = 1'b0;
      q_d.ck_oe = 1'b0;
      q_d.ck = 1'b0;
      q_d.cs_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= '{st: D_POR, cnt: 32'h0, bits: 32'h0, div: 4'h0, ck: 1'b0, ck_oe: 1'b0,
               sh: 32'h0, cmd_out: 1'b0, cs_n: 1'b1, status_oe: 1'b1, done_oe: 1'b1,
               init_oe: 1'b0, umode: 1'b0, rx_valid: 1'b0, rx_data: 4'h0, udata: 1'b0,
               prev_ck: 1'b1, prev_uc: 1'b1, armed: 1'b0, edges: 2'h0};
    end else begin
      q_q <= q_d;
    end
  end

  assign link.status_dev_oe = q_q.status_oe;
  assign link.done_oe = q_q.done_oe;
  assign link.clk_dev = q_q.ck;
  assign link.clk_dev_oe = q_q.ck_oe;
  assign link.flash_command_out = q_q.cmd_out;
  assign link.flash_select_n = q_q.cs_n;
  assign link.init_done_oe = q_q.init_oe;
  assign rx_valid = q_q.rx_valid;
  assign rx_data = q_q.rx_data;
  assign user_mode = q_q.umode;
  assign user_data_in = q_q.udata;
endmodule

// File: logic/cfg_pkg.sv
/*
  Shared constants, types and decoding for both ends of the serial
  configuration link. Assumes a 200 MHz system clock on both ends.
*/
package cfg_pkg;
  localparam int CLK_NS = 5;
  localparam int POR_CYC = 64;
  localparam int REQ_LOW_NS = 2000;
  localparam int REQ_LOW_CYC = (REQ_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ST2CK_NS = 2000;
  localparam int ST2CK_CYC = (ST2CK_NS + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MAX_US = 1506;
  localparam int CD2UM_MIN_US = 175;
  localparam int CD2UM_MAX_US = 437;
  localparam int INIT_CLOCKS = 8576;
  localparam int CU_PERIODS = 4;
  localparam int CFG_CLK_MAX_PERIOD_NS = 80;
  localparam int CU_CYC = (CU_PERIODS * CFG_CLK_MAX_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int END_EDGES = 2;
  localparam logic [3:0] HALF_SLOW = 4'h8;
  localparam logic [1:0] RANGE_FASTEST = 2'h3;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int FLASH_HDR_BITS = 32;
  localparam logic [5:0] WORD_BITS = 6'h20;

  // Controller register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] LEN_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  localparam int CTRL_START = 0;
  localparam int CTRL_MONITOR = 1;
  localparam int CTRL_HOLD = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {SRC_OSC, SRC_USER, SRC_CFGCLK} init_src_type;

  // Half period of the generated clock in system cycles
  function automatic logic [3:0] half_period(input logic [1:0] range, input logic chain);
    logic [1:0] r;
    r = (chain && range == RANGE_FASTEST) ? RANGE_FASTEST - 2'h1 : range;
    return HALF_SLOW >> r;
  endfunction
endpackage

// File: logic/cfg_link_if.sv
/*
  Pin-level link between the configurable device and its host.
  Open-drain lines resolve here with a pull-up; flash data is driven
  by whatever sits on flash_data_lines outside both ends.
*/
interface cfg_link_if;
  logic request_n;
  logic status_dev_oe;
  logic status_host_oe;
  logic status_n;
  logic done_oe;
  logic done;
  logic clk_dev;
  logic clk_dev_oe;
  logic clk_host;
  logic clk_host_oe;
  logic config_clock;
  logic data_host;
  logic data_host_oe;
  logic serial_config_data;
  logic [3:0] flash_data_lines;
  logic flash_command_out;
  logic flash_select_n;
  logic init_done_oe;
  logic init_done_n;

  assign status_n = !(status_dev_oe || status_host_oe);
  assign done = !done_oe;
  assign config_clock = clk_dev_oe ? clk_dev : (clk_host_oe ? clk_host : 1'b0);
  assign serial_config_data = data_host_oe ? data_host : flash_data_lines[0];
  assign init_done_n = !init_done_oe;

  modport device(
    input request_n, status_n, config_clock, serial_config_data, flash_data_lines,
    output status_dev_oe, done_oe, clk_dev, clk_dev_oe, flash_command_out,
    output flash_select_n, init_done_oe
  );
  modport host(
    input status_n, done,
    output request_n, status_host_oe, clk_host, clk_host_oe, data_host, data_host_oe
  );
endinterface

// File: logic/cfg_sync.sv
/*
  Two-stage synchroniser for a group of levels from another domain.
  Assumes each bit may be sampled independently.
*/
module cfg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;
  sync_type q_q;
  sync_type q_d;

  always_comb begin
    q_d.s1 = d;
    q_d.s2 = q_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= {INIT, INIT};
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q.s2;
endmodule

// File: logic/cfg_host.sv
/*
  Host end: passive serial loader driven by software over AXI4-Lite.
  Assumes software writes LEN, then CTRL start, then feeds DATA words.
*/
module cfg_host
  import cfg_pkg::*;
#(
  parameter int HALF_CYC = 4,
  parameter int WAIT_CYC = (STATUS_MAX_US * 1000 + CLK_NS - 1) / CLK_NS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Configuration pins
  cfg_link_if.host link
);
  if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk_half
    $error("HALF_CYC out of range");
  end

  typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_GAP, H_SHIFT, H_DONE, H_EDGES} hstate_type;
  typedef struct packed {
    hstate_type st;
    logic [31:0] cnt;
    logic [31:0] len;
    logic [31:0] sent;
    logic [31:0] sh;
    logic [5:0] nb;
    logic [7:0] div;
    logic ck;
    logic dat;
    logic drv;
    logic req_n;
    logic mon;
    logic hold;
    logic err;
    logic fin;
    logic [7:0] awa;
    logic awv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wv;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } host_type;

  host_type q_q;
  host_type q_d;
  logic s_status;
  logic s_done;
  logic tick;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  cfg_sync #(.W(2), .INIT(2'h0)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.status_n, link.done}),
    .q({s_status, s_done})
  );

  always_comb begin
    q_d = q_q;
    tick = 1'b0;
    if (q_q.div == 8'(HALF_CYC - 1)) begin
      q_d.div = 8'h0;
      tick = 1'b1;
    end else begin
      q_d.div = q_q.div + 8'h1;
    end
    unique case (q_q.st)
      H_IDLE: ;
      H_REQ: begin
        q_d.cnt = q_q.cnt + 32'h1;
        if (q_q.cnt == 32'(REQ_LOW_CYC - 1)) begin // R9
          q_d.req_n = 1'b1;
          q_d.cnt = 32'h0;
          q_d.st = H_WAIT;
        end
      end
      H_WAIT: begin
        q_d.cnt = q_q.cnt + 32'h1;
        if (q_q.mon ? s_status : (q_q.cnt == 32'(WAIT_CYC - 1))) begin // R11
          q_d.st = q_q.mon ? H_GAP : H_SHIFT;
          q_d.cnt = 32'h0;
        end
      end
      H_GAP: begin
        q_d.cnt = q_q.cnt + 32'h1;
        if (q_q.cnt == 32'(ST2CK_CYC - 1)) begin // R11
          q_d.st = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (!q_q.ck) begin
          q_d.dat = q_q.sh[0];
        end
        // Rise only once the pin already shows the bit
        if (tick) begin
          if (q_q.ck) begin
            q_d.ck = 1'b0;
          end else if (q_q.nb != 6'h0 && q_q.dat == q_q.sh[0]) begin // R12 R13
            q_d.ck = 1'b1;
            q_d.sh = q_q.sh >> 1;
            q_d.nb = q_q.nb - 6'h1;
            q_d.sent = q_q.sent + 32'h1;
            if (q_q.sent + 32'h1 >= q_q.len) begin
              q_d.st = H_DONE;
            end
          end
        end
      end
      H_DONE: begin
        if (tick && q_q.ck) begin
          q_d.ck = 1'b0;
        end
        if (s_done && !q_q.ck) begin
          q_d.st = H_EDGES;
          q_d.cnt = 32'h0;
        end
      end
      H_EDGES: begin
        if (tick) begin // R14
          q_d.ck = !q_q.ck;
          if (q_q.ck) begin
            q_d.cnt = q_q.cnt + 32'h1;
            if (q_q.cnt == 32'(END_EDGES - 1)) begin
              q_d.st = H_IDLE;
              q_d.fin = 1'b1;
              q_d.drv = 1'b0;
            end
          end
        end
      end
    endcase
    if (q_q.mon && !s_status && (q_q.st == H_GAP || q_q.st == H_SHIFT || q_q.st == H_DONE)) begin
      q_d.err = 1'b1; // R21
      q_d.st = H_IDLE;
      q_d.drv = 1'b0;
      q_d.ck = 1'b0;
    end

    if (q_q.awrdy && awvalid) begin
      q_d.awv = 1'b1;
      q_d.awa = awaddr;
    end
    if (q_q.wrdy && wvalid) begin
      q_d.wv = 1'b1;
      q_d.wd = wdata;
      q_d.ws = wstrb;
    end
    if (q_q.bvalid && bready) begin
      q_d.bvalid = 1'b0;
    end
    // A data word waits in the bus until the last one is sent
    if (q_q.awv && q_q.wv && !q_q.bvalid && (q_q.awa != DATA_OFS || q_q.nb == 6'h0)) begin
      q_d.awv = 1'b0;
      q_d.wv = 1'b0;
      q_d.bvalid = 1'b1;
      q_d.bresp = RESP_OKAY;
      unique case (q_q.awa)
        CTRL_OFS: begin
          if (q_q.ws[0]) begin
            q_d.mon = q_q.wd[CTRL_MONITOR];
            q_d.hold = q_q.wd[CTRL_HOLD];
            if (q_q.wd[CTRL_START] && q_q.st == H_IDLE) begin // R5 R21
              q_d.st = H_REQ;
              q_d.cnt = 32'h0;
              q_d.req_n = 1'b0;
              q_d.err = 1'b0;
              q_d.fin = 1'b0;
              q_d.sent = 32'h0;
              q_d.nb = 6'h0;
              q_d.ck = 1'b0;
              q_d.drv = 1'b1;
            end
          end
        end
        STAT_OFS: ;
        LEN_OFS: q_d.len = merge(q_q.len, q_q.wd, q_q.ws);
        DATA_OFS: begin
          q_d.sh = q_q.wd;
          q_d.nb = WORD_BITS;
        end
        default: q_d.bresp = RESP_DECERR;
      endcase
    end
    if (q_q.rvalid && rready) begin
      q_d.rvalid = 1'b0;
    end
    if (q_q.arrdy && arvalid) begin
      q_d.rvalid = 1'b1;
      q_d.rresp = RESP_OKAY;
      unique case (araddr)
        CTRL_OFS: q_d.rdata = {29'h0, q_q.hold, q_q.mon, 1'b0};
        STAT_OFS: q_d.rdata = {27'h0, s_done, q_q.nb == 6'h0, q_q.fin, q_q.err,
                               q_q.st != H_IDLE};
        LEN_OFS: q_d.rdata = q_q.len;
        default: begin
          q_d.rdata = 32'h0;
          q_d.rresp = RESP_DECERR;
        end
      endcase
    end
    q_d.awrdy = !q_d.awv && !q_d.bvalid;
    q_d.wrdy = !q_d.wv && !q_d.bvalid;
    q_d.arrdy = !q_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= '0;
      q_q.st <= H_IDLE;
      q_q.req_n <= 1'b1;
    end else begin
      q_q <= q_d;
    end
  end

  assign awready = q_q.awrdy;
  assign wready = q_q.wrdy;
  assign bvalid = q_q.bvalid;
  assign bresp = q_q.bresp;
  assign arready = q_q.arrdy;
  assign rvalid = q_q.rvalid;
  assign rresp = q_q.rresp;
  assign rdata = q_q.rdata;
  assign link.request_n = q_q.req_n;
  assign link.status_host_oe = q_q.hold;
  assign link.clk_host = q_q.ck;
  assign link.clk_host_oe = q_q.drv;
  assign link.data_host = q_q.dat;
  assign link.data_host_oe = q_q.drv;
endmodule

// File: sim/cfg_assertions.sv
/*
  Pin checks on the configuration link.
  Fed the link interface signals by the bench top; no bind.
*/
module cfg_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link lines
  input wire logic request_n,
  input wire logic status_n,
  input wire logic done,
  input wire logic status_dev_oe,
  input wire logic done_oe,
  input wire logic init_done_oe,
  input wire logic clk_dev,
  input wire logic flash_select_n,
  input wire logic flash_command_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench status count 200 plus synchroniser lag
  localparam int ST_MAX = 215;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  req_pull_a: assert property ($fell(request_n) |-> ##[1:120] !status_n && !done)
    else $error("status or done not pulled low");
  req_hold_a: assert property (!request_n [*6] |-> status_dev_oe && done_oe)
    else $error("request low but lines released");
  st_min_a: assert property ($rose(request_n) |-> status_dev_oe [*8])
    else $error("status released too early");
  st_max_a: assert property ($rose(request_n) |-> ##[1:ST_MAX] !status_dev_oe)
    else $error("status not released in time");
  done_st_a: assert property ($rose(status_dev_oe) |-> ##[0:1] done_oe)
    else $error("done not held low with status");
  done_rel_a: assert property ($rose(done) |-> request_n && status_n)
    else $error("done released during reset phase");
  idone_a: assert property (init_done_oe |-> done)
    else $error("init done driven before done");
  fall_launch_a: assert property (!flash_select_n && !$past(flash_select_n)
    && $changed(flash_command_out) |-> $fell(clk_dev))
    else $error("flash command changed off falling edge");
  cover property ($rose(done));
  cover property ($fell(flash_select_n));
  cover property ($rose(status_n));
endmodule

// File: sim/test_serial_config_sequencer.sv
/*
  Bench: passive load through the host registers, then an active
  quad load from a flash model. Assumes 200 MHz aclk.
*/
module test_serial_config_sequencer;
  import cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic uclk = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic act = 1'b0;
  logic quad = 1'b0;
  logic chain = 1'b0;
  logic ide = 1'b0;
  logic dpu = 1'b0;
  logic [1:0] rng = 2'h0;
  init_src_type src = SRC_OSC;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, w;
  logic rx_valid, user_mode, user_data_in, pclk;
  logic [3:0] rx_data;
  logic [3:0] e;
  logic [1:0] rs;
  logic [7:0] r = 8'h56;
  logic [3:0] q[$];
  int n_errors = 0;
  int check_count = 0;
  int falls = 0;
  cfg_link_if link();
  always #2.5 aclk = ~aclk;
  always #24 uclk = ~uclk;
  cfg_device #(.LOAD_BITS(32), .STATUS_CYC(200), .INIT_OSC_CYC(100), .INIT_CLK_COUNT(16))
    u_cfg_device (.aclk(aclk), .aresetn(aresetn), .link(link), .active_serial_mode(act),
    .quad_mode(quad), .clock_range(rng), .chain_mode(chain), .init_src(src),
    .init_done_enable(ide), .data_pin_user(dpu), .user_init_clock(uclk),
    .rx_valid(rx_valid), .rx_data(rx_data), .user_mode(user_mode),
    .user_data_in(user_data_in));
  cfg_host #(.WAIT_CYC(600)) u_cfg_host (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
  cfg_assertions u_cfg_assertions (.aclk(aclk), .aresetn(aresetn),
    .request_n(link.request_n), .status_n(link.status_n), .done(link.done),
    .status_dev_oe(link.status_dev_oe), .done_oe(link.done_oe),
    .init_done_oe(link.init_done_oe), .clk_dev(link.clk_dev),
    .flash_select_n(link.flash_select_n), .flash_command_out(link.flash_command_out));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= LIM) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // Late bready keeps the response standing for a cycle
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && k < LIM);
    tmo(k);
    check("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && k < LIM);
    d = rdata;
    rs = rresp;
    tmo(k);
  endtask
  task automatic wum(input logic v);
    int k;
    for (k = 0; k < LIM && user_mode !== v; k++) @(posedge aclk);
    tmo(k);
  endtask
  // Flash model: released lines toggle so stale data never matches
  always @(posedge aclk) begin
    pclk <= link.clk_dev;
    if (link.flash_select_n !== 1'b0) begin
      falls <= 0;
      link.flash_data_lines <= ~link.flash_data_lines;
    end else if (pclk && !link.clk_dev) begin
      falls <= falls + 1;
      if (falls >= 31 && falls < 39) begin
        r = nx(r);
        link.flash_data_lines <= r[3:0];
        q.push_back(r[3:0]);
      end
    end
  end
  always @(posedge aclk) begin
    if (rx_valid === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : 4'hx;
      check("rx", {28'h0, rx_data & (quad ? 4'hf : 4'h1)}, {28'h0, e});
    end
  end
  initial begin
    link.flash_data_lines = 4'h5;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      r = nx(r);
      w = {r, w[31:8]};
    end
    for (int i = 0; i < 32; i++) q.push_back({3'h0, w[i]});
    wr(LEN_OFS, 32'h20);
    wr(CTRL_OFS, 32'h3);
    wr(DATA_OFS, w);
    wum(1'b1);
    rd(STAT_OFS);
    check("stat", d & 32'h14, 32'h14);
    check("left", q.size(), 32'h0);
    check("udata", {31'h0, user_data_in}, 32'h0);
    rd(8'h10);
    check("resp", {30'h0, rs}, {30'h0, RESP_DECERR});
    act <= 1'b1;
    quad <= 1'b1;
    chain <= 1'b1;
    ide <= 1'b1;
    dpu <= 1'b1;
    rng <= 2'h1;
    src <= SRC_USER;
    wr(CTRL_OFS, 32'h1);
    wum(1'b0);
    wum(1'b1);
    check("left2", q.size(), 32'h0);
    check("falls", {31'h0, falls == 0}, 32'h1);
    report_and_stop();
  end
endmodule
